// ===== logic/acp_cfg.svh
// constants of the conversion and power control block: offsets, fields,
// reset values and timing counts
// assumes a 20 MHz clock and a 16-bit register port
`ifndef ACP_CFG_SVH
`define ACP_CFG_SVH
`define ACP_ADDR_W        4
`define ACP_DATA_W        16
`define ACP_ADDR_CONFIG   4'h0
`define ACP_ADDR_STATUS   4'h4
`define ACP_ADDR_COUNT    4'h8
`define ACP_CFG_PD_CMD    0
`define ACP_CFG_PD_SRC    1
`define ACP_CFG_SCALED    2
`define ACP_CFG_W         3
`define ACP_CFG_RESET     3'h0
`define ACP_ST_BUSY       0
`define ACP_ST_PWRDN      1
`define ACP_ST_LOWI       2
`define ACP_ST_REF        3
`define ACP_ST_BUF        4
`define ACP_ST_TEMP       5
`define ACP_ST_EXTIN      6
`define ACP_ST_RSTH       7
`define ACP_COUNT_RESET   16'h0000
`define ACP_CLK_PERIOD_NS 50
`define ACP_CONV_TIME_NS  700
`define ACP_CONV_CYCLES   ((`ACP_CONV_TIME_NS + `ACP_CLK_PERIOD_NS - 1) / `ACP_CLK_PERIOD_NS)
`define ACP_CNT_W         5
`endif

// ===== logic/acp_pkg.sv
// types shared by the conversion and power control block
// assumes acp_cfg.svh is on the include path
`include "acp_cfg.svh"
package acp_pkg;
  typedef enum logic [1:0] {
    st_acquire,
    st_convert,
    st_power_down,
    st_reset_hold
  } acp_state_e;

  typedef struct packed {
    logic scaled_mode;
    logic pd_src_reg;
    logic pd_cmd;
  } acp_cfg_s;

  typedef struct packed {
    logic use_buffer_reference_input;
    logic temp_on;
    logic buf_on;
    logic int_ref_on;
  } acp_ref_s;

  typedef logic [`ACP_DATA_W-1:0] acp_data_t;
  typedef logic [`ACP_ADDR_W-1:0] acp_addr_t;
endpackage : acp_pkg

// ===== logic/acp_edge_det.sv
// edge detector for a level that is already synchronous to clk
// assumes the input idles at IDLE_LEVEL out of reset
`timescale 1ns/100ps
`default_nettype none
module acp_edge_det
  import acp_pkg::*;
#(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic level,
  output var  logic rise,
  output var  logic fall
);
  logic prev_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_q <= IDLE_LEVEL;
    end else begin
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;
endmodule : acp_edge_det
`default_nettype wire

// ===== logic/acp_conv_timer.sv
// conversion timer: counts a fixed number of clocks per conversion
// assumes start is only raised while idle; abort wins over done
`timescale 1ns/100ps
`default_nettype none
`include "acp_cfg.svh"
module acp_conv_timer
  import acp_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic start,
  input  wire logic abort,
  output var  logic busy,
  output var  logic done
);
  localparam int W = `ACP_CNT_W;
  localparam logic [W-1:0] LAST = W'(`ACP_CONV_CYCLES - 1);

  logic         busy_q;
  logic [W-1:0] cnt_q;

  assign done = busy_q & (cnt_q == '0) & ~abort;
  assign busy = busy_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
    end else if (busy_q) begin
      busy_q <= ~(abort | done);
      cnt_q  <= cnt_q - W'(1);
    end else if (start) begin
      busy_q <= 1'b1;
      cnt_q  <= LAST;
    end
  end

  done_when_busy_a : assert property (@(posedge clk) disable iff (!nrst)
    done |-> busy_q && $past(busy_q)) else $error("timer done without a running count");
endmodule : acp_conv_timer
`default_nettype wire

// ===== logic/acp_top.sv
// conversion start, power-down, scaled power and reference control
// assumes all pins are synchronous to clk; the register port never waits
`timescale 1ns/100ps
`default_nettype none
`include "acp_cfg.svh"

// Functional notes
// R1: a falling edge on conversion_start_n alone launches a conversion
// R2: a running conversion completes; new starts and power-down cannot stop it
// R3: starting ignores chip select and read enable entirely
// R4: power_down_pin high puts the converter into minimum-current power-down
// R5: power-down waits for the running conversion; the bus stays active
// R6: with register control selected, power_down_pin is ignored
// R7: scaled-power mode drops to low current after each conversion
// R8: the register interface keeps working during acquisition
// R9: both reference pins low enable internal reference, buffer and temperature output
// R10: reference off, buffer on: buffer the external buffer_reference_input
// R11: both reference pins high disable reference and buffer
// R12: temperature output only while the internal reference is on
// R13: reset pin high aborts and tristates; its fall clears configuration
// R14: starts during a running conversion are dropped, never queued
module acp_top
  import acp_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      nrst,
  input  wire logic      conversion_start_n,
  input  wire logic      power_down_pin,
  input  wire logic      reference_off_pin,
  input  wire logic      ref_buffer_off_pin,
  input  wire logic      conv_reset_pin,
  input  wire logic      chip_select_n,
  input  wire logic      read_enable_n,
  input  wire acp_addr_t addr,
  input  wire acp_data_t wr_data,
  input  wire logic      wr_en,
  input  wire logic      rd_en,
  output var  acp_data_t rd_data,
  output var  logic      busy,
  output var  logic      conv_done,
  output var  logic      powered_down,
  output var  logic      low_current,
  output var  acp_ref_s  ref_ctrl,
  output var  logic      data_bus_oe
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  acp_state_e state_q;
  acp_state_e state_d;
  acp_cfg_s   cfg_q;
  acp_cfg_s   cfg_d;
  acp_ref_s   ref_q;
  acp_ref_s   ref_d;
  acp_data_t  rd_data_q;
  acp_data_t  rd_mux;
  acp_data_t  count_q;
  logic       busy_q;
  logic       done_q;
  logic       pwrdn_q;
  logic       lowi_q;
  logic       oe_q;
  logic       conv_fall;
  logic       rst_fall;
  logic       conv_go;
  logic       pd_req;
  logic       tmr_busy;
  logic       tmr_done;

  // ----------------------------------------------------------------
  // pin edges and conversion timer
  // ----------------------------------------------------------------
  acp_edge_det #(
    .IDLE_LEVEL (1'b1)
  ) u_start_edge (
    .clk   (clk),
    .nrst  (nrst),
    .level (conversion_start_n),
    .rise  (),
    .fall  (conv_fall)
  );

  acp_edge_det #(
    .IDLE_LEVEL (1'b0)
  ) u_reset_edge (
    .clk   (clk),
    .nrst  (nrst),
    .level (conv_reset_pin),
    .rise  (),
    .fall  (rst_fall)
  );

  // chip select and read enable play no part in launching
  assign conv_go = (state_q == st_acquire) & conv_fall & ~conv_reset_pin; // R1 R3

  acp_conv_timer u_timer (
    .clk   (clk),
    .nrst  (nrst),
    .start (conv_go),
    .abort (conv_reset_pin), // R13
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  // ----------------------------------------------------------------
  // power-down request
  // ----------------------------------------------------------------
  // host must still tie the pin; the mux only stops it from glitching state
  assign pd_req = cfg_q.pd_src_reg ? cfg_q.pd_cmd : power_down_pin; // R6

  // ----------------------------------------------------------------
  // operating state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      st_acquire: begin
        if (conv_reset_pin) begin
          state_d = st_reset_hold; // R13
        end else if (conv_fall) begin
          state_d = st_convert; // R1
        end else if (pd_req) begin
          state_d = st_power_down; // R4
        end
      end
      st_convert: begin
        // start edges are not looked at here; pd_req only once tmr_done is high
        if (conv_reset_pin) begin
          state_d = st_reset_hold; // R13
        end else if (tmr_done) begin
          state_d = pd_req ? st_power_down : st_acquire; // R2 R5 R14
        end
      end
      st_power_down: begin
        if (conv_reset_pin) begin
          state_d = st_reset_hold;
        end else if (!pd_req) begin
          state_d = st_acquire;
        end
      end
      st_reset_hold: begin
        if (!conv_reset_pin) begin
          state_d = st_acquire;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= st_acquire;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      pwrdn_q <= 1'b0;
      lowi_q  <= 1'b0;
    end else begin
      busy_q  <= (state_d == st_convert); // R2
      done_q  <= tmr_done;
      pwrdn_q <= (state_d == st_power_down); // R4 R5
      // low current after each conversion costs wake-up only on the next start
      lowi_q  <= (state_d == st_power_down) | (cfg_d.scaled_mode & (state_d == st_acquire)); // R7
    end
  end

  // ----------------------------------------------------------------
  // reference control
  // ----------------------------------------------------------------
  always_comb begin
    ref_d.int_ref_on                 = ~reference_off_pin; // R9 R10 R11
    ref_d.buf_on                     = ~ref_buffer_off_pin; // R9 R10 R11
    ref_d.temp_on                    = ~reference_off_pin & ~ref_buffer_off_pin; // R12
    ref_d.use_buffer_reference_input = reference_off_pin & ~ref_buffer_off_pin; // R10
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_q <= '0;
    end else begin
      ref_q <= ref_d;
    end
  end

  // ----------------------------------------------------------------
  // data bus enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ~conv_reset_pin & ~chip_select_n & ~read_enable_n; // R13
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_comb begin
    cfg_d = cfg_q;
    if (rst_fall) begin
      cfg_d = `ACP_CFG_RESET; // R13
    end else if (wr_en && addr == `ACP_ADDR_CONFIG) begin
      cfg_d = wr_data[`ACP_CFG_W-1:0]; // R5 R8
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= `ACP_CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // wraps silently; software reads differences
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= `ACP_COUNT_RESET;
    end else if (rst_fall) begin
      count_q <= `ACP_COUNT_RESET;
    end else if (tmr_done) begin
      count_q <= count_q + 16'h0001;
    end
  end

  always_comb begin
    rd_mux = '0;
    unique case (addr)
      `ACP_ADDR_CONFIG: begin
        rd_mux[`ACP_CFG_W-1:0] = cfg_q;
      end
      `ACP_ADDR_STATUS: begin
        rd_mux[`ACP_ST_BUSY]  = busy_q;
        rd_mux[`ACP_ST_PWRDN] = pwrdn_q;
        rd_mux[`ACP_ST_LOWI]  = lowi_q;
        rd_mux[`ACP_ST_REF]   = ref_q.int_ref_on;
        rd_mux[`ACP_ST_BUF]   = ref_q.buf_on;
        rd_mux[`ACP_ST_TEMP]  = ref_q.temp_on;
        rd_mux[`ACP_ST_EXTIN] = ref_q.use_buffer_reference_input;
        rd_mux[`ACP_ST_RSTH]  = (state_q == st_reset_hold);
      end
      `ACP_ADDR_COUNT: begin
        rd_mux = count_q;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // read port runs in every state, power-down included
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= rd_en ? rd_mux : '0; // R8
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_data      = rd_data_q;
  assign busy         = busy_q;
  assign conv_done    = done_q;
  assign powered_down = pwrdn_q;
  assign low_current  = lowi_q;
  assign ref_ctrl     = ref_q;
  assign data_bus_oe  = oe_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int CONV_CYC = `ACP_CONV_CYCLES;

  logic [7:0] busy_len_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_len_q <= '0;
    end else begin
      busy_len_q <= busy_q ? busy_len_q + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence launch_s;
    state_q == st_acquire && conv_fall && !conv_reset_pin;
  endsequence

  sequence running_s;
    busy_q && !conv_reset_pin;
  endsequence

  sequence idle_pd_s;
    state_q == st_acquire && pd_req && !conv_reset_pin && !conv_fall;
  endsequence

  start_launch_a : assert property ( // R1
    launch_s |=> busy_q && tmr_busy && !pwrdn_q) else $error("start edge did not launch");

  start_no_cs_a : assert property ( // R3
    launch_s ##0 (chip_select_n || read_enable_n) |=> busy_q) else $error("launch depended on cs or rd");

  conv_length_a : assert property ( // R2
    $fell(busy_q) && !$past(conv_reset_pin) |-> busy_len_q == 8'(CONV_CYC)) else $error("conversion cut short");

  conv_ignore_a : assert property ( // R14
    running_s ##0 conv_fall ##0 !tmr_done |=> busy_q && busy_len_q == $past(busy_len_q) + 8'h01)
    else $error("start edge disturbed running conversion");

  no_queue_a : assert property ( // R14
    running_s ##0 conv_fall ##1 !busy_q ##1 !conv_fall |=> !busy_q) else $error("start edge was queued");

  pd_entry_a : assert property ( // R4
    idle_pd_s |=> pwrdn_q && lowi_q && !busy_q) else $error("power-down not entered");

  pd_waits_a : assert property ( // R5
    running_s ##0 pd_req ##0 !tmr_done |=> busy_q && !pwrdn_q) else $error("power-down aborted conversion");

  pd_after_conv_a : assert property ( // R5
    running_s ##0 tmr_done ##0 pd_req |=> pwrdn_q && !busy_q) else $error("power-down not taken after conversion");

  pin_ignored_a : assert property ( // R6
    state_q == st_acquire && cfg_q.pd_src_reg && !cfg_q.pd_cmd && !conv_reset_pin && !conv_fall
    |=> !pwrdn_q) else $error("pin acted while register selected");

  scaled_low_a : assert property ( // R7
    (state_d == st_acquire) && cfg_d.scaled_mode |=> lowi_q && !busy_q) else $error("no low current in acquisition");

  bus_active_a : assert property ( // R8
    rd_en && addr == `ACP_ADDR_STATUS && !busy_q
    |=> rd_data_q[`ACP_ST_BUSY] == 1'b0 && rd_data_q[`ACP_ST_LOWI] == $past(lowi_q))
    else $error("status read wrong during acquisition");

  cfg_write_a : assert property ( // R5
    wr_en && addr == `ACP_ADDR_CONFIG && pwrdn_q && !rst_fall
    |=> cfg_q == $past(wr_data[`ACP_CFG_W-1:0])) else $error("write lost in power-down");

  ref_internal_a : assert property ( // R9
    !reference_off_pin && !ref_buffer_off_pin |=> ref_q.int_ref_on && ref_q.buf_on && ref_q.temp_on)
    else $error("internal reference not enabled");

  ref_ext_buf_a : assert property ( // R10
    reference_off_pin && !ref_buffer_off_pin
    |=> !ref_q.int_ref_on && ref_q.buf_on && ref_q.use_buffer_reference_input)
    else $error("external buffered reference wrong");

  ref_ext_direct_a : assert property ( // R11
    reference_off_pin && ref_buffer_off_pin |=> !ref_q.int_ref_on && !ref_q.buf_on && !ref_q.temp_on)
    else $error("direct external reference wrong");

  temp_gate_a : assert property ( // R12
    ref_q.temp_on |-> ref_q.int_ref_on && ref_q.buf_on) else $error("temperature output without reference");

  reset_abort_a : assert property ( // R13
    conv_reset_pin |=> !busy_q && !data_bus_oe && !tmr_done) else $error("reset pin did not abort");

  reset_clear_a : assert property ( // R13
    rst_fall |=> cfg_q == `ACP_CFG_RESET && count_q == `ACP_COUNT_RESET) else $error("config not cleared");
endmodule : acp_top
`default_nettype wire

// ===== sim/acp_host_model.sv
// host-side model: drives conversion start, power-down and reference pins
// assumes the bench calls its tasks; pins change by nba just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module acp_host_model #(
  parameter int LOW_CYCLES = 2
) (
  input  wire logic clk,
  output var  logic conversion_start_n,
  output var  logic power_down_pin,
  output var  logic reference_off_pin,
  output var  logic ref_buffer_off_pin
);
  // ----------------------------------------------------------------
  // pin levels
  // ----------------------------------------------------------------
  int low_cnt = 0;

  initial begin
    conversion_start_n = 1'b1;
    power_down_pin     = 1'b0;
    reference_off_pin  = 1'b0;
    ref_buffer_off_pin = 1'b0;
  end

  // a plain falling edge is all a conversion needs
  task automatic start_conv();
    @(posedge clk);
    conversion_start_n <= 1'b0;
    low_cnt            <= LOW_CYCLES;
  endtask : start_conv

  // the pin returns high on its own, so every later call makes a real edge
  always @(posedge clk) begin
    if (low_cnt > 0) begin
      low_cnt <= low_cnt - 1;
      if (low_cnt == 1) begin
        conversion_start_n <= 1'b1;
      end
    end
  end

  // levels held until the next call; with register control in use the host
  // normally leaves the power-down pin at a fixed level
  task automatic set_pins(input logic pd, input logic ref_off, input logic buf_off);
    @(posedge clk);
    power_down_pin     <= pd;
    reference_off_pin  <= ref_off;
    ref_buffer_off_pin <= buf_off;
  endtask : set_pins
endmodule : acp_host_model
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the conversion and power control block
// assumes acp_pkg and acp_cfg.svh are compiled first; one 20 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "acp_cfg.svh"
module testbench;
  import acp_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic     ref_off;
    logic     buf_off;
    logic     cs_n;
    logic     rd_n;
    acp_ref_s ref_exp;
    logic     oe_exp;
  } acp_row_s;

  logic      clk = 1'b0;
  logic      nrst, conv_reset_pin, chip_select_n, read_enable_n, wr_en, rd_en;
  acp_addr_t addr;
  acp_data_t wr_data, rd_data;
  logic      busy, conv_done, powered_down, low_current, data_bus_oe;
  logic      conversion_start_n, power_down_pin, reference_off_pin, ref_buffer_off_pin;
  acp_ref_s  ref_ctrl;
  int        n_mismatch = 0;
  int        comparisons = 0;
  int        cycles = 0;
  acp_row_s  rows [4] = '{'{1'b0, 1'b0, 1'b0, 1'b0, 4'b0111, 1'b1},
                          '{1'b1, 1'b0, 1'b1, 1'b0, 4'b1010, 1'b0},
                          '{1'b1, 1'b1, 1'b0, 1'b1, 4'b0000, 1'b0},
                          '{1'b0, 1'b1, 1'b0, 1'b0, 4'b0001, 1'b1}};

  always #25 clk = ~clk;

  acp_host_model #(.LOW_CYCLES(2)) acp_host_model_i (
    .clk(clk), .conversion_start_n(conversion_start_n), .power_down_pin(power_down_pin),
    .reference_off_pin(reference_off_pin), .ref_buffer_off_pin(ref_buffer_off_pin));

  acp_top acp_top_i (
    .clk(clk), .nrst(nrst), .conversion_start_n(conversion_start_n), .power_down_pin(power_down_pin),
    .reference_off_pin(reference_off_pin), .ref_buffer_off_pin(ref_buffer_off_pin),
    .conv_reset_pin(conv_reset_pin), .chip_select_n(chip_select_n), .read_enable_n(read_enable_n),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .busy(busy),
    .conv_done(conv_done), .powered_down(powered_down), .low_current(low_current),
    .ref_ctrl(ref_ctrl), .data_bus_oe(data_bus_oe));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input acp_addr_t a, input acp_data_t v);
    @(posedge clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= v;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdc(input acp_addr_t a, input acp_data_t exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(rd_data, exp);
  endtask : rdc

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // n: cycles busy stood high, d: done pulse at its fall, lc: low_current at its rise
  task automatic measure(output int n, output logic d, output logic lc);
    n = 0;
    for (int i = 0; i < 4 && busy !== 1'b1; i++) begin
      cyc(1);
    end
    lc = low_current;
    while (busy === 1'b1 && n < 20) begin
      n++;
      cyc(1);
    end
    d = conv_done;
  endtask : measure

  // a hang counts against the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int   n;
    logic d, lc, seen;
    nrst = 1'b0;
    conv_reset_pin = 1'b0;
    chip_select_n = 1'b0;
    read_enable_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'h0;
    wr_data = 16'h0000;
    cyc(10);
    check(16'({busy, powered_down, data_bus_oe, ref_ctrl}), 16'h0000);
    @(posedge clk);
    nrst <= 1'b1;
    rdc(`ACP_ADDR_CONFIG, 16'h0000);
    foreach (rows[i]) begin
      acp_host_model_i.set_pins(1'b0, rows[i].ref_off, rows[i].buf_off);
      chip_select_n <= rows[i].cs_n;
      read_enable_n <= rows[i].rd_n;
      cyc(2);
      check(16'(ref_ctrl), 16'(rows[i].ref_exp));
      check(16'(data_bus_oe), 16'(rows[i].oe_exp));
    end
    // start with chip select and read enable both idle
    @(posedge clk);
    chip_select_n <= 1'b1;
    read_enable_n <= 1'b1;
    acp_host_model_i.start_conv();
    measure(n, d, lc);
    check(16'(n), 16'h000E);
    check(16'(d), 16'h0001);
    rdc(`ACP_ADDR_COUNT, 16'h0001);
    // second fall while busy must be dropped, not queued
    acp_host_model_i.start_conv();
    cyc(4);
    acp_host_model_i.start_conv();
    measure(n, d, lc);
    check(16'(d), 16'h0001);
    seen = 1'b0;
    repeat (20) begin
      cyc(1);
      seen = seen | busy;
    end
    check(16'(seen), 16'h0000);
    // power-down pin raised mid-conversion
    acp_host_model_i.start_conv();
    cyc(3);
    acp_host_model_i.set_pins(1'b1, 1'b0, 1'b1);
    measure(n, d, lc);
    check(16'(d), 16'h0001);
    check(16'({powered_down, low_current}), 16'h0003);
    rdc(`ACP_ADDR_COUNT, 16'h0003);
    rdc(`ACP_ADDR_STATUS, 16'h000E);
    acp_host_model_i.set_pins(1'b0, 1'b0, 1'b1);
    cyc(2);
    check(16'(powered_down), 16'h0000);
    // register control: pin level has no say
    wr(`ACP_ADDR_CONFIG, 16'h0003);
    cyc(2);
    check(16'(powered_down), 16'h0001);
    acp_host_model_i.set_pins(1'b1, 1'b0, 1'b1);
    wr(`ACP_ADDR_CONFIG, 16'h0002);
    cyc(2);
    check(16'(powered_down), 16'h0000);
    acp_host_model_i.set_pins(1'b0, 1'b0, 1'b1);
    // scaled-power mode
    wr(`ACP_ADDR_CONFIG, 16'h0004);
    cyc(2);
    check(16'(low_current), 16'h0001);
    rdc(`ACP_ADDR_CONFIG, 16'h0004);
    acp_host_model_i.start_conv();
    measure(n, d, lc);
    check(16'({lc, n[4:0], d, low_current}), 16'({1'b0, 5'd14, 1'b1, 1'b1}));
    rdc(4'hC, 16'h0000);
    rdc(`ACP_ADDR_COUNT, 16'h0004);
    // reset pin aborts mid-conversion and tristates, its fall clears config
    @(posedge clk);
    chip_select_n <= 1'b0;
    read_enable_n <= 1'b0;
    acp_host_model_i.start_conv();
    cyc(5);
    @(posedge clk);
    conv_reset_pin <= 1'b1;
    seen = 1'b0;
    repeat (3) begin
      cyc(1);
      seen = seen | conv_done;
    end
    check(16'({busy, seen, data_bus_oe}), 16'h0000);
    rdc(`ACP_ADDR_STATUS, 16'h0088);
    @(posedge clk);
    conv_reset_pin <= 1'b0;
    cyc(2);
    rdc(`ACP_ADDR_CONFIG, 16'h0000);
    rdc(`ACP_ADDR_COUNT, 16'h0000);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
